// >>> rtl/fpeg_defs.svh
`ifndef FPEG_DEFS_SVH
`define FPEG_DEFS_SVH

// key codes
`define FPEG_KEY_FIRST 8'ha5
`define FPEG_KEY_SECOND 8'hf1
// lock state codes read from the key register
`define FPEG_LOCK_LOCKED 2'h0
`define FPEG_LOCK_FIRST 2'h1
`define FPEG_LOCK_OPEN 2'h2
`define FPEG_LOCK_BLOCKED 2'h3
// control register fields
`define FPEG_CTL_WE_BIT 0
`define FPEG_CTL_EE_BIT 1
`define FPEG_CTL_RESET 8'h00
// flash and ram geometry
`define FPEG_FLASH_BYTES 16384
`define FPEG_PAGE_BYTES 512
`define FPEG_USER_TOP 16'h3dff
`define FPEG_RAM_BYTES 2048
`define FPEG_ERASED 8'hff
// timing
`define FPEG_CLK_MHZ 20
`define FPEG_WRITE_TIME_US 40
`define FPEG_ERASE_TIME_MS 10
`define FPEG_WRITE_CYC (`FPEG_WRITE_TIME_US * `FPEG_CLK_MHZ)
`define FPEG_ERASE_CYC (`FPEG_ERASE_TIME_MS * 1000 * `FPEG_CLK_MHZ)
// host register offsets
`define FPEG_REG_CMD 32'h0000_0000
`define FPEG_REG_ADDR 32'h0000_0004
`define FPEG_REG_STAT 32'h0000_0008
// host register fields
`define FPEG_CMD_OP_LSB 0
`define FPEG_CMD_DATA_LSB 8
`define FPEG_STAT_BUSY_BIT 0
`define FPEG_STAT_FERR_BIT 1
`define FPEG_STAT_DATA_LSB 8
`define FPEG_RESP_OKAY 2'h0
`define FPEG_RESP_SLVERR 2'h2
`endif

// >>> rtl/fpeg_pkg.sv
package fpeg_pkg;
   // lock and key states
   typedef enum logic [3:0] {
      FPEG_KS_LOCKED = 4'b0001,
      FPEG_KS_FIRST = 4'b0010,
      FPEG_KS_OPEN = 4'b0100,
      FPEG_KS_BLOCKED = 4'b1000
   } fpeg_key_t;
   // core access kinds
   typedef enum logic [2:0] {
      FPEG_OP_KEY_WR = 3'h0,
      FPEG_OP_CTL_WR = 3'h1,
      FPEG_OP_KEY_RD = 3'h2,
      FPEG_OP_CTL_RD = 3'h3,
      FPEG_OP_XM_WR = 3'h4,
      FPEG_OP_XM_RD = 3'h5,
      FPEG_OP_CM_RD = 3'h6
   } fpeg_op_t;
   // host sequencer states
   typedef enum logic [3:0] {
      FPEG_HS_IDLE = 4'b0001,
      FPEG_HS_WAIT = 4'b0010,
      FPEG_HS_ISSUE = 4'b0100,
      FPEG_HS_CAPT = 4'b1000
   } fpeg_hst_t;
endpackage : fpeg_pkg

// >>> rtl/fpeg_if.sv
`timescale 1ns/1ns
interface fpeg_if;
   logic key_wr;
   logic ctl_wr;
   logic key_rd;
   logic ctl_rd;
   logic xm_wr;
   logic xm_rd;
   logic cm_rd;
   logic [15:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic stall;
   logic ferr_flag;
   modport core (output key_wr, ctl_wr, key_rd, ctl_rd, xm_wr, xm_rd, cm_rd, addr, wdata,
                 input rdata, stall, ferr_flag);
   modport guard (input key_wr, ctl_wr, key_rd, ctl_rd, xm_wr, xm_rd, cm_rd, addr, wdata,
                  output rdata, stall, ferr_flag);
endinterface : fpeg_if

// >>> rtl/fpeg_op_timer.sv
`timescale 1ns/1ns
module fpeg_op_timer import fpeg_pkg::*; #(
   parameter int WIDTH = 18
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic start,
   input wire logic [WIDTH-1:0] load,
   output logic done
);
   logic [WIDTH-1:0] count_reg;
   logic run_reg;

   // counts the operation length down, done pulses on the last cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_reg <= '0;
         run_reg <= 1'b0;
      end else if (start) begin
         count_reg <= load;
         run_reg <= 1'b1;
      end else if (run_reg) begin
         count_reg <= count_reg - 1'b1;
         if (count_reg == {{(WIDTH-1){1'b0}}, 1'b1}) begin
            run_reg <= 1'b0;
         end
      end
   end

   assign done = run_reg && (count_reg == {{(WIDTH-1){1'b0}}, 1'b1});
endmodule : fpeg_op_timer

// >>> rtl/fpeg_device.sv
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ns
`include "fpeg_defs.svh"
module fpeg_device import fpeg_pkg::*; #(
   parameter int ERASE_CYCLES = `FPEG_ERASE_CYC,
   parameter int WRITE_CYCLES = `FPEG_WRITE_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic por_n,
   fpeg_if.guard bus,
   input wire logic dbg_req,
   input wire logic dbg_erase,
   input wire logic [15:0] dbg_addr,
   input wire logic [7:0] dbg_wdata,
   output logic dbg_busy,
   output logic flash_error_flag,
   output logic flash_error_reset
);
   localparam int TW = 18;
   localparam int PW = 9;
   localparam logic [7:0] CTL_RST = `FPEG_CTL_RESET;

   logic [7:0] flash_mem [0:`FPEG_FLASH_BYTES-1];
   logic [7:0] ram_mem [0:`FPEG_RAM_BYTES-1];
   fpeg_key_t key_reg;
   logic program_store_write_enable_reg;
   logic program_store_erase_enable_reg;
   logic busy_reg;
   logic erase_op_reg;
   logic [13:0] op_addr_reg;
   logic [PW-1:0] wipe_idx_reg;
   logic wipe_run_reg;
   logic [7:0] rdata_reg;
   logic ferr_reg;
   logic ferr_rst_reg;
   logic flash_wr;
   logic addr_bad;
   logic cm_bad;
   logic cpu_go;
   logic dbg_go;
   logic op_go;
   logic op_erase;
   logic [13:0] op_addr;
   logic [7:0] op_data;
   logic timer_done;
   logic [TW-1:0] timer_load;

   // maps the lock state onto its readable code
   function automatic logic [1:0] lock_code(input fpeg_key_t k);
      unique case (k)
         FPEG_KS_LOCKED: lock_code = `FPEG_LOCK_LOCKED;
         FPEG_KS_FIRST: lock_code = `FPEG_LOCK_FIRST;
         FPEG_KS_OPEN: lock_code = `FPEG_LOCK_OPEN;
         FPEG_KS_BLOCKED: lock_code = `FPEG_LOCK_BLOCKED;
         default: lock_code = `FPEG_LOCK_BLOCKED;
      endcase
   endfunction : lock_code

   // true for addresses in the reserved top page or beyond
   function automatic logic beyond_user(input logic [15:0] a);
      beyond_user = (a > `FPEG_USER_TOP);
   endfunction : beyond_user

   // steering of core and debug requests into flash operations
   assign flash_wr = bus.xm_wr && program_store_write_enable_reg && !busy_reg;
   assign addr_bad = beyond_user(bus.addr);
   assign cm_bad = bus.cm_rd && addr_bad;
   assign cpu_go = flash_wr && !addr_bad && (key_reg == FPEG_KS_OPEN);
   assign dbg_go = dbg_req && !busy_reg && !bus.xm_wr && !beyond_user(dbg_addr);
   assign op_go = cpu_go || dbg_go;
   assign op_erase = cpu_go ? program_store_erase_enable_reg : dbg_erase;
   assign op_addr = cpu_go ? bus.addr[13:0] : dbg_addr[13:0];
   assign op_data = cpu_go ? bus.wdata : dbg_wdata;
   assign timer_load = op_erase ? TW'(ERASE_CYCLES) : TW'(WRITE_CYCLES);

   fpeg_op_timer #(
      .WIDTH(TW)
   ) u_timer (
      .aclk(aclk),
      .aresetn(aresetn),
      .start(op_go),
      .load(timer_load),
      .done(timer_done)
   );

   // lock and key sequence
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         key_reg <= FPEG_KS_LOCKED;
      end else if (flash_wr && !addr_bad) begin
         if (key_reg == FPEG_KS_OPEN) begin
            key_reg <= FPEG_KS_LOCKED;
         end else begin
            key_reg <= FPEG_KS_BLOCKED;
         end
      end else if (bus.key_wr) begin
         unique case (key_reg)
            FPEG_KS_LOCKED: begin
               key_reg <= (bus.wdata == `FPEG_KEY_FIRST) ? FPEG_KS_FIRST
                          : FPEG_KS_BLOCKED;
            end
            FPEG_KS_FIRST: begin
               key_reg <= (bus.wdata == `FPEG_KEY_SECOND) ? FPEG_KS_OPEN
                          : FPEG_KS_BLOCKED;
            end
            FPEG_KS_OPEN: key_reg <= FPEG_KS_BLOCKED;
            FPEG_KS_BLOCKED: key_reg <= FPEG_KS_BLOCKED;
            default: key_reg <= FPEG_KS_BLOCKED;
         endcase
      end
      // other traffic between the two keys leaves the first-key state alone, except a flash write to a user address, which blocks it
   end

   // program store control bits, changed only by software
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         program_store_write_enable_reg <= CTL_RST[`FPEG_CTL_WE_BIT];
         program_store_erase_enable_reg <= CTL_RST[`FPEG_CTL_EE_BIT];
      end else if (bus.ctl_wr) begin
         program_store_write_enable_reg <= bus.wdata[`FPEG_CTL_WE_BIT];
         program_store_erase_enable_reg <= bus.wdata[`FPEG_CTL_EE_BIT];
      end
   end

   // operation in progress, held until the timer expires
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         busy_reg <= 1'b0;
         erase_op_reg <= 1'b0;
         op_addr_reg <= '0;
      end else if (op_go) begin
         busy_reg <= 1'b1;
         erase_op_reg <= op_erase;
         op_addr_reg <= op_addr;
      end else if (timer_done) begin
         busy_reg <= 1'b0;
      end
   end

   // walks every byte of the erased page, one per cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wipe_idx_reg <= '0;
         wipe_run_reg <= 1'b0;
      end else if (op_go && op_erase) begin
         wipe_idx_reg <= '0;
         wipe_run_reg <= 1'b1;
      end else if (wipe_run_reg) begin
         wipe_idx_reg <= wipe_idx_reg + 1'b1;
         if (wipe_idx_reg == PW'(`FPEG_PAGE_BYTES - 1)) begin
            wipe_run_reg <= 1'b0;
         end
      end
   end

   // flash array updates
   always_ff @(posedge aclk) begin
      if (op_go && !op_erase) begin
         flash_mem[op_addr] <= flash_mem[op_addr] & op_data;
      end else if (wipe_run_reg) begin
         flash_mem[{op_addr_reg[13:PW], wipe_idx_reg}] <= `FPEG_ERASED;
      end
   end

   // data ram writes when write-enable is clear
   always_ff @(posedge aclk) begin
      if (bus.xm_wr && !program_store_write_enable_reg) begin
         ram_mem[bus.addr[10:0]] <= bus.wdata;
      end
   end

   // read data for register, ram and code reads
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rdata_reg <= 8'h00;
      end else if (bus.key_rd) begin
         rdata_reg <= {6'h00, lock_code(key_reg)};
      end else if (bus.ctl_rd) begin
         rdata_reg <= {6'h00, program_store_erase_enable_reg, program_store_write_enable_reg};
      end else if (bus.xm_rd) begin
         rdata_reg <= ram_mem[bus.addr[10:0]];
      end else if (bus.cm_rd && !cm_bad) begin
         rdata_reg <= flash_mem[bus.addr[13:0]];
      end
   end

   // error reset request pulse on out-of-range flash access
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ferr_rst_reg <= 1'b0;
      end else begin
         ferr_rst_reg <= (flash_wr && addr_bad) || cm_bad;
      end
   end

   // error flag survives the system reset it causes
   always_ff @(posedge aclk) begin
      if (!por_n) begin
         ferr_reg <= 1'b0;
      end else if ((flash_wr && addr_bad) || cm_bad) begin
         ferr_reg <= 1'b1;
      end else if (!aresetn) begin
         ferr_reg <= ferr_reg;
      end else if (op_go) begin
         ferr_reg <= 1'b0;
      end
   end

   // outputs
   assign bus.stall = busy_reg;
   assign bus.rdata = rdata_reg;
   assign bus.ferr_flag = ferr_reg;
   assign dbg_busy = busy_reg;
   assign flash_error_flag = ferr_reg;
   assign flash_error_reset = ferr_rst_reg;
endmodule : fpeg_device

// >>> rtl/fpeg_host.sv
`timescale 1ns/1ns
`include "fpeg_defs.svh"
module fpeg_host import fpeg_pkg::*; (
   input wire logic aclk,
   input wire logic aresetn,
   fpeg_if.core bus,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   fpeg_hst_t state_reg;
   fpeg_op_t op_reg;
   logic [15:0] addr_reg;
   logic [7:0] data_reg;
   logic [7:0] rd_reg;
   logic [6:0] strobe_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;
   logic wr_take;
   logic cmd_go;
   logic busy;

   assign busy = (state_reg != FPEG_HS_IDLE);
   assign wr_take = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
   assign cmd_go = wr_take && (s_axi_awaddr == `FPEG_REG_CMD) && !busy && s_axi_wstrb[0];

   // write channel handshake and response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= `FPEG_RESP_OKAY;
      end else if (wr_take) begin
         bvalid_reg <= 1'b1;
         if ((s_axi_awaddr == `FPEG_REG_CMD && !busy) || s_axi_awaddr == `FPEG_REG_ADDR) begin
            bresp_reg <= `FPEG_RESP_OKAY;
         end else begin
            bresp_reg <= `FPEG_RESP_SLVERR;
         end
      end else if (s_axi_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   // address register and command fields
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         addr_reg <= 16'h0000;
         op_reg <= FPEG_OP_KEY_RD;
         data_reg <= 8'h00;
      end else if (wr_take && s_axi_awaddr == `FPEG_REG_ADDR) begin
         if (s_axi_wstrb[0]) addr_reg[7:0] <= s_axi_wdata[7:0];
         if (s_axi_wstrb[1]) addr_reg[15:8] <= s_axi_wdata[15:8];
      end else if (cmd_go) begin
         op_reg <= fpeg_op_t'(s_axi_wdata[`FPEG_CMD_OP_LSB +: 3]);
         data_reg <= s_axi_wdata[`FPEG_CMD_DATA_LSB +: 8];
      end
   end

   // access sequencer: wait out the stall, strobe once, capture read data
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= FPEG_HS_IDLE;
         strobe_reg <= 7'h00;
         rd_reg <= 8'h00;
      end else begin
         unique case (state_reg)
            FPEG_HS_IDLE: begin
               strobe_reg <= 7'h00;
               if (cmd_go) state_reg <= FPEG_HS_WAIT;
            end
            FPEG_HS_WAIT: begin
               if (!bus.stall) begin
                  strobe_reg <= 7'h01 << op_reg;
                  state_reg <= FPEG_HS_ISSUE;
               end
            end
            FPEG_HS_ISSUE: begin
               strobe_reg <= 7'h00;
               state_reg <= FPEG_HS_CAPT;
            end
            FPEG_HS_CAPT: begin
               rd_reg <= bus.rdata;
               state_reg <= FPEG_HS_IDLE;
            end
            default: state_reg <= FPEG_HS_IDLE;
         endcase
      end
   end

   // read channel with status register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= `FPEG_RESP_OKAY;
      end else if (s_axi_arvalid && !rvalid_reg) begin
         rvalid_reg <= 1'b1;
         rresp_reg <= `FPEG_RESP_OKAY;
         rdata_reg <= 32'h0000_0000;
         if (s_axi_araddr == `FPEG_REG_STAT) begin
            rdata_reg[`FPEG_STAT_BUSY_BIT] <= busy || bus.stall;
            rdata_reg[`FPEG_STAT_FERR_BIT] <= bus.ferr_flag;
            rdata_reg[`FPEG_STAT_DATA_LSB +: 8] <= rd_reg;
         end else if (s_axi_araddr == `FPEG_REG_ADDR) begin
            rdata_reg[15:0] <= addr_reg;
         end else if (s_axi_araddr != `FPEG_REG_CMD) begin
            rresp_reg <= `FPEG_RESP_SLVERR;
         end
      end else if (s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   // interface drive, strobe bit order follows the access kind codes
   assign bus.key_wr = strobe_reg[FPEG_OP_KEY_WR];
   assign bus.ctl_wr = strobe_reg[FPEG_OP_CTL_WR];
   assign bus.key_rd = strobe_reg[FPEG_OP_KEY_RD];
   assign bus.ctl_rd = strobe_reg[FPEG_OP_CTL_RD];
   assign bus.xm_wr = strobe_reg[FPEG_OP_XM_WR];
   assign bus.xm_rd = strobe_reg[FPEG_OP_XM_RD];
   assign bus.cm_rd = strobe_reg[FPEG_OP_CM_RD];
   assign bus.addr = addr_reg;
   assign bus.wdata = data_reg;
   assign s_axi_awready = wr_take;
   assign s_axi_wready = wr_take;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = !rvalid_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
endmodule : fpeg_host

// >>> bench/fpeg_properties.sv
`timescale 1ns/1ns
`include "fpeg_defs.svh"
module fpeg_properties #(
   parameter int ERASE_CYCLES = 600,
   parameter int WRITE_CYCLES = 4
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic key_wr,
   input wire logic ctl_wr,
   input wire logic key_rd,
   input wire logic ctl_rd,
   input wire logic xm_wr,
   input wire logic xm_rd,
   input wire logic cm_rd,
   input wire logic [15:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic stall,
   input wire logic ferr_flag
);
   logic [1:0] ks_reg;
   logic [1:0] ctl_reg;
   logic [31:0] run_reg;
   logic any_rd;
   logic any_st;
   logic go;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // strobe summaries and a flash write that the lock logic must judge
   assign any_rd = key_rd | ctl_rd | xm_rd | cm_rd;
   assign any_st = any_rd | key_wr | ctl_wr | xm_wr;
   assign go = xm_wr & ctl_reg[0] & !stall & (addr <= `FPEG_USER_TOP);
   // expected lock state
   always_ff @(posedge aclk) begin
      if (!aresetn)
         ks_reg <= `FPEG_LOCK_LOCKED;
      else if (key_wr)
         ks_reg <= (ks_reg == `FPEG_LOCK_LOCKED && wdata == `FPEG_KEY_FIRST) ? `FPEG_LOCK_FIRST :
                   (ks_reg == `FPEG_LOCK_FIRST && wdata == `FPEG_KEY_SECOND) ? `FPEG_LOCK_OPEN :
                   `FPEG_LOCK_BLOCKED;
      else if (go)
         ks_reg <= (ks_reg == `FPEG_LOCK_OPEN) ? `FPEG_LOCK_LOCKED : `FPEG_LOCK_BLOCKED;
   end
   // expected enables
   always_ff @(posedge aclk) begin
      if (!aresetn)
         ctl_reg <= 2'h0;
      else if (ctl_wr)
         ctl_reg <= wdata[1:0];
   end
   // length of the current stall
   always_ff @(posedge aclk) begin
      if (!aresetn || !stall)
         run_reg <= 32'h0;
      else
         run_reg <= run_reg + 32'h1;
   end
   key_state_a: assert property (key_rd |=> rdata == {6'h0, $past(ks_reg)})
      else $error("lock state read differs");
   ctl_read_a: assert property (ctl_rd |=> rdata == {6'h0, $past(ctl_reg)})
      else $error("control read differs");
   op_start_a: assert property (go |=> stall == ($past(ks_reg) == `FPEG_LOCK_OPEN))
      else $error("flash operation start wrong");
   ram_path_a: assert property (xm_wr && !ctl_reg[0] |=> !stall)
      else $error("data ram write stalled");
   stall_len_a: assert property ($fell(stall) |-> run_reg == WRITE_CYCLES ||
      run_reg == ERASE_CYCLES) else $error("operation length wrong");
   stall_hold_a: assert property (stall |-> !any_st)
      else $error("access during stall");
   strobe_pulse_a: assert property (any_st |=> !any_st)
      else $error("strobe longer than one cycle");
   ferr_cause_a: assert property ($rose(ferr_flag) |->
      $past((xm_wr & ctl_reg[0] | cm_rd) & (addr > `FPEG_USER_TOP)))
      else $error("error flag without cause");
   cm_err_a: assert property (cm_rd && addr > `FPEG_USER_TOP |=> ferr_flag)
      else $error("reserved read not flagged");
   rdata_hold_a: assert property (!any_rd |=> $stable(rdata))
      else $error("read data moved");
endmodule : fpeg_properties

// >>> bench/tb_flash_program_erase_guard.sv
`timescale 1ns/1ns
module tb_flash_program_erase_guard import fpeg_pkg::*; ;
   logic aclk = 0, aresetn = 0, por_n = 0;
   logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, dbg_req = 0, dbg_erase = 0, dbg_busy, flash_error_flag;
   logic flash_error_reset;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [15:0] dbg_addr = '0;
   logic [7:0] dbg_wdata = '0, q;
   logic [31:0] s;
   int errors = 0, n_checks = 0, err_cnt = 0, e;
   // ordinary cases: op, address, data or expected read
   logic [26:0] rows [28] = '{
      {FPEG_OP_KEY_RD, 16'h0, 8'h00}, {FPEG_OP_CTL_RD, 16'h0, 8'h00},
      {FPEG_OP_KEY_WR, 16'h0, 8'ha5}, {FPEG_OP_KEY_RD, 16'h0, 8'h01},
      {FPEG_OP_XM_WR, 16'h0010, 8'h3c}, {FPEG_OP_KEY_WR, 16'h0, 8'hf1},
      {FPEG_OP_KEY_RD, 16'h0, 8'h02}, {FPEG_OP_CTL_WR, 16'h0, 8'h03},
      {FPEG_OP_XM_WR, 16'h0210, 8'h00}, {FPEG_OP_KEY_RD, 16'h0, 8'h00},
      {FPEG_OP_CTL_RD, 16'h0, 8'h03}, {FPEG_OP_CM_RD, 16'h0200, 8'hff},
      {FPEG_OP_CM_RD, 16'h03ff, 8'hff}, {FPEG_OP_XM_RD, 16'h0810, 8'h3c},
      {FPEG_OP_KEY_WR, 16'h0, 8'ha5}, {FPEG_OP_KEY_WR, 16'h0, 8'hf1},
      {FPEG_OP_CTL_WR, 16'h0, 8'h01}, {FPEG_OP_XM_WR, 16'h0210, 8'h5a},
      {FPEG_OP_CM_RD, 16'h0210, 8'h5a}, {FPEG_OP_KEY_WR, 16'h0, 8'ha5},
      {FPEG_OP_KEY_WR, 16'h0, 8'hf1}, {FPEG_OP_XM_WR, 16'h0210, 8'hf0},
      {FPEG_OP_CM_RD, 16'h0210, 8'h50}, {FPEG_OP_CM_RD, 16'h0211, 8'hff},
      {FPEG_OP_CTL_WR, 16'h0, 8'h00}, {FPEG_OP_XM_WR, 16'h0020, 8'h77},
      {FPEG_OP_XM_RD, 16'h0020, 8'h77}, {FPEG_OP_KEY_RD, 16'h0, 8'h00}};
   // clock and error reset pulse counter
   always #25 aclk = ~aclk;
   always @(posedge aclk) if (flash_error_reset === 1'b1) err_cnt++;
   fpeg_if bus_if ();
   fpeg_host fpeg_host_inst (.aclk, .aresetn, .bus(bus_if), .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   fpeg_device #(.ERASE_CYCLES(600), .WRITE_CYCLES(4)) fpeg_device_inst (.aclk, .aresetn,
      .por_n, .bus(bus_if), .dbg_req, .dbg_erase, .dbg_addr, .dbg_wdata, .dbg_busy,
      .flash_error_flag, .flash_error_reset);
   fpeg_properties #(.ERASE_CYCLES(600), .WRITE_CYCLES(4)) fpeg_properties_inst (.aclk,
      .aresetn, .key_wr(bus_if.key_wr), .ctl_wr(bus_if.ctl_wr), .key_rd(bus_if.key_rd),
      .ctl_rd(bus_if.ctl_rd), .xm_wr(bus_if.xm_wr), .xm_rd(bus_if.xm_rd),
      .cm_rd(bus_if.cm_rd), .addr(bus_if.addr), .wdata(bus_if.wdata), .rdata(bus_if.rdata),
      .stall(bus_if.stall), .ferr_flag(bus_if.ferr_flag));
   task results;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : results
   task check(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", nm, exp, got);
      end
   endtask : check
   task give_up;
      check("wait", 0, 1);
      results();
   endtask : give_up
   // one write on the register bus
   task axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] rs);
      int n;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while (s_axi_bvalid !== 1'b1 && n < 100);
      rs = s_axi_bresp;
      s_axi_bready <= 0;
      if (n >= 100) give_up();
   endtask : axi_wr
   // one read on the register bus
   task axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] rs);
      int n;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 0;
      end while (s_axi_rvalid !== 1'b1 && n < 100);
      d = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 0;
      if (n >= 100) give_up();
   endtask : axi_rd
   // poll status until the sequencer is idle and the device no longer stalls, then return the last read byte
   task wait_idle(output logic [7:0] qd);
      int n;
      n = 0;
      do begin
         axi_rd(32'h8, s, r);
         n++;
      end while (s[0] !== 1'b0 && n < 1000);
      if (n >= 1000) give_up();
      qd = s[15:8];
   endtask : wait_idle
   task core_op(input logic [2:0] op, input logic [15:0] a, input logic [7:0] d);
      axi_wr(32'h4, {16'h0, a}, r);
      axi_wr(32'h0, {16'h0, d, 5'h0, op}, r);
      check("command response", 2'h0, r);
      wait_idle(q);
   endtask : core_op
   task rst;
      @(posedge aclk);
      aresetn <= 0;
      repeat (5) @(posedge aclk);
      aresetn <= 1;
   endtask : rst
   task dbg_op(input logic er, input logic [15:0] a, input logic [7:0] d, input logic w);
      int n;
      @(posedge aclk);
      dbg_req <= 1;
      dbg_erase <= er;
      dbg_addr <= a;
      dbg_wdata <= d;
      @(posedge aclk);
      dbg_req <= 0;
      n = 0;
      while (w && n < 1000 && (n == 0 || dbg_busy !== 1'b0)) begin
         @(posedge aclk);
         n++;
      end
      if (n >= 1000) give_up();
   endtask : dbg_op
   // main sequence
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1;
      por_n <= 1;
      for (int i = 0; i < 28; i++) begin
         core_op(rows[i][26:24], rows[i][23:8], rows[i][7:0]);
         if (rows[i][26:24] inside {FPEG_OP_KEY_RD, FPEG_OP_CTL_RD, FPEG_OP_XM_RD, FPEG_OP_CM_RD})
            check($sformatf("row %0d", i), rows[i][7:0], q);
      end
      // reserved flash address with write enable set
      core_op(FPEG_OP_CTL_WR, 16'h0, 8'h01);
      e = err_cnt;
      core_op(FPEG_OP_XM_WR, 16'h3e00, 8'h00);
      check("error flag", 1, flash_error_flag);
      check("error resets", e + 1, err_cnt);
      axi_rd(32'h8, s, r);
      check("status error bit", 1, s[1]);
      @(posedge aclk);
      por_n <= 0;
      @(posedge aclk);
      por_n <= 1;
      @(posedge aclk);
      check("flag after power-on reset", 0, flash_error_flag);
      core_op(FPEG_OP_CM_RD, 16'h3fff, 8'h00);
      check("read error flag", 1, flash_error_flag);
      // flash write while locked, then keys are ignored
      core_op(FPEG_OP_XM_WR, 16'h0100, 8'h00);
      core_op(FPEG_OP_KEY_WR, 16'h0, 8'ha5);
      core_op(FPEG_OP_KEY_RD, 16'h0, 8'h00);
      check("blocked after early write", 2'h3, q);
      for (int i = 0; i < 2; i++) begin
         rst();
         if (i == 1) core_op(FPEG_OP_KEY_WR, 16'h0, 8'ha5);
         core_op(FPEG_OP_KEY_WR, 16'h0, (i == 1) ? 8'h00 : 8'hf1);
         core_op(FPEG_OP_KEY_RD, 16'h0, 8'h00);
         check("blocked after bad key", 2'h3, q);
      end
      rst();
      core_op(FPEG_OP_KEY_RD, 16'h0, 8'h00);
      check("lock after reset", 2'h0, q);
      core_op(FPEG_OP_CTL_RD, 16'h0, 8'h00);
      check("enables after reset", 2'h0, q);
      axi_wr(32'hc, 32'h0, r);
      check("unmapped write", 2'h2, r);
      axi_rd(32'hc, s, r);
      check("unmapped read", 2'h2, r);
      // debug port programs a locked part
      dbg_op(1, 16'h0400, 8'h00, 1);
      dbg_op(0, 16'h0401, 8'h12, 1);
      core_op(FPEG_OP_CM_RD, 16'h0401, 8'h00);
      check("debug program", 8'h12, q);
      core_op(FPEG_OP_CM_RD, 16'h0400, 8'h00);
      check("debug erase", 8'hff, q);
      axi_rd(32'h4, s, r);
      check("address readback", 32'h0000_0400, s);
      // second command refused while the first waits on a stall
      dbg_op(1, 16'h0400, 8'h00, 0);
      axi_wr(32'h0, {29'h0, FPEG_OP_CM_RD}, r);
      axi_wr(32'h0, {29'h0, FPEG_OP_CM_RD}, r);
      check("command while busy", 2'h2, r);
      wait_idle(q);
      check("read after debug erase", 8'hff, q);
      results();
   end
endmodule : tb_flash_program_erase_guard
